// *** src/odac_pkg.sv ***
// ****************************************************************
// constants and types of the octal dac update control
// ****************************************************************
package odac_pkg;

  localparam int NCH = 8;
  localparam int DATA_W = 16;
  localparam int FRAME_W = 24;

  // command codes carried in the top nibble of a frame
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [3:0] CMD_UPDATE = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_MASK = 4'h5;
  localparam logic [3:0] CMD_SWRST = 4'h6;
  localparam logic [3:0] CMD_GAIN = 4'h7;

  // software reset check values
  localparam logic [3:0] SWRST_ADDR = 4'h0;
  localparam logic [15:0] SWRST_KEY = 16'h1234;

  // field positions inside the data word
  localparam int MASK_LSB = 0;
  localparam int GAIN_BIT = 2;

  // values after reset
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic GAIN_RST = 1'b0;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;

  // link side bit counter
  localparam logic [4:0] BIT_FIRST = 5'h00;
  localparam logic [4:0] BIT_LAST = 5'h17;

  // power-on interval
  localparam int CLK_PERIOD_NS = 50;
  localparam int POR_TIME_NS = 10000;
  localparam int POR_CYCLES = (POR_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] POR_FIRST = 8'h00;
  localparam logic [7:0] POR_LAST = 8'(POR_CYCLES - 1);

  typedef struct packed {
    logic [3:0] cmd;
    logic [3:0] addr;
    logic [15:0] data;
  } odac_frame_t;

  typedef enum logic [1:0] {
    ST_POR = 2'b00,
    ST_WAIT = 2'b01,
    ST_RUN = 2'b10
  } odac_state_t;

endpackage

// *** src/odac_update_ctrl.sv ***
`timescale 1ns/1ns
module odac_update_ctrl (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic link_clk,
  input wire logic frame_n,
  input wire logic link_data,
  input wire logic load_dac_strobe_n,
  input wire logic hw_reset_n,
  input wire logic reset_level_select,
  output logic [7:0][15:0] channel_output,
  output logic gain_two,
  output logic init_done
);

  // ****************************************************************
  // link domain: frame shifter
  // ****************************************************************
  logic [4:0] bit_cnt_q;
  logic [22:0] shift_q;
  odac_pkg::odac_frame_t word_q;
  logic tog_q;

  // the counter is cleared by the frame signal itself, since the link
  // clock may stop as soon as a frame ends
  always_ff @(posedge link_clk or posedge sys_rst or posedge frame_n)
  begin
    if (sys_rst || frame_n)
    begin
      bit_cnt_q <= odac_pkg::BIT_FIRST;
    end
    else if (bit_cnt_q == odac_pkg::BIT_LAST)
    begin
      bit_cnt_q <= odac_pkg::BIT_FIRST;
    end
    else
    begin
      bit_cnt_q <= bit_cnt_q + 5'h01;
    end
  end

  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      shift_q <= 23'h000000;
    end
    else if (!frame_n)
    begin
      shift_q <= {shift_q[21:0], link_data};
    end
  end

  // word stays put for a whole frame, so the system side may sample it
  // a few cycles after the toggle without tearing
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      word_q <= '0;
      tog_q <= 1'b0;
    end
    else if (!frame_n && bit_cnt_q == odac_pkg::BIT_LAST)
    begin
      word_q <= {shift_q, link_data};
      tog_q <= ~tog_q;
    end
  end

  // ****************************************************************
  // synchronisers into the system clock
  // ****************************************************************
  logic tg_s1_q, tg_s2_q, tg_s3_q;
  logic ld_s1_q, ld_s2_q, ld_s3_q;
  logic hr_s1_q, hr_s2_q;
  logic sel_s1_q, sel_s2_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
    end
    else
    begin
      tg_s1_q <= tog_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
    end
  end

  // strobe and reset pins idle high; reset values avoid a false edge at release
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ld_s1_q <= 1'b1;
      ld_s2_q <= 1'b1;
      ld_s3_q <= 1'b1;
      hr_s1_q <= 1'b1;
      hr_s2_q <= 1'b1;
      sel_s1_q <= 1'b0;
      sel_s2_q <= 1'b0;
    end
    else
    begin
      ld_s1_q <= load_dac_strobe_n;
      ld_s2_q <= ld_s1_q;
      ld_s3_q <= ld_s2_q;
      hr_s1_q <= hw_reset_n;
      hr_s2_q <= hr_s1_q;
      sel_s1_q <= reset_level_select;
      sel_s2_q <= sel_s1_q;
    end
  end

  // ****************************************************************
  // decode
  // ****************************************************************
  odac_pkg::odac_state_t state_q;
  logic run;
  logic frm_v;
  logic ld_fall;
  logic hr_act;
  logic [15:0] clear_val;
  logic is_wr, is_up, is_wu, is_mask, is_sw, is_gain;
  logic sw_ok;

  assign run = (state_q == odac_pkg::ST_RUN);
  assign frm_v = run && (tg_s2_q != tg_s3_q);
  assign ld_fall = ld_s3_q && !ld_s2_q;
  assign hr_act = !hr_s2_q;
  assign clear_val = sel_s2_q ? odac_pkg::CODE_MID : odac_pkg::CODE_ZERO;
  assign is_wr = frm_v && word_q.cmd == odac_pkg::CMD_WRITE;
  assign is_up = frm_v && word_q.cmd == odac_pkg::CMD_UPDATE;
  assign is_wu = frm_v && word_q.cmd == odac_pkg::CMD_WRITE_UPD;
  assign is_mask = frm_v && word_q.cmd == odac_pkg::CMD_MASK;
  assign is_sw = frm_v && word_q.cmd == odac_pkg::CMD_SWRST;
  assign is_gain = frm_v && word_q.cmd == odac_pkg::CMD_GAIN;
  assign sw_ok = is_sw && word_q.addr == odac_pkg::SWRST_ADDR
    && word_q.data == odac_pkg::SWRST_KEY;

  // ****************************************************************
  // power-on sequence
  // ****************************************************************
  logic [7:0] por_cnt_q;
  logic ready_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= odac_pkg::ST_POR;
      por_cnt_q <= odac_pkg::POR_FIRST;
      ready_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        odac_pkg::ST_POR:
        begin
          // strobe is not looked at here; reset pin is only checked on the last count
          if (por_cnt_q == odac_pkg::POR_LAST)
          begin
            por_cnt_q <= odac_pkg::POR_FIRST;
            if (hr_s2_q)
            begin
              state_q <= odac_pkg::ST_RUN;
              ready_q <= 1'b1;
            end
            else
            begin
              state_q <= odac_pkg::ST_WAIT;
            end
          end
          else
          begin
            por_cnt_q <= por_cnt_q + 8'h01;
          end
        end
        odac_pkg::ST_WAIT:
        begin
          if (hr_s2_q)
          begin
            state_q <= odac_pkg::ST_RUN;
            ready_q <= 1'b1;
          end
        end
        odac_pkg::ST_RUN:
        begin
          if (sw_ok)
          begin
            state_q <= odac_pkg::ST_POR;
            ready_q <= 1'b0;
          end
        end
        default:
        begin
          state_q <= odac_pkg::ST_POR;
          ready_q <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // mask and gain registers
  // ****************************************************************
  logic [7:0] mask_q;
  logic gain_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mask_q <= odac_pkg::MASK_RST;
    end
    else if (!run)
    begin
      mask_q <= odac_pkg::MASK_RST;
    end
    else if (is_mask)
    begin
      // address nibble is not consulted
      mask_q <= word_q.data[odac_pkg::MASK_LSB +: 8];
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      gain_q <= odac_pkg::GAIN_RST;
    end
    else if (!run)
    begin
      gain_q <= odac_pkg::GAIN_RST;
    end
    else if (is_gain)
    begin
      gain_q <= word_q.data[odac_pkg::GAIN_BIT];
    end
  end

  // ****************************************************************
  // channel registers
  // ****************************************************************
  logic [7:0][15:0] in_q;
  logic [7:0][15:0] dac_q;

  for (genvar i = 0; i < odac_pkg::NCH; i++)
  begin : g_ch
    logic hit;
    assign hit = (word_q.addr == 4'(i));

    always_ff @(posedge clock or posedge sys_rst)
    begin
      if (sys_rst)
      begin
        in_q[i] <= odac_pkg::CODE_ZERO;
        dac_q[i] <= odac_pkg::CODE_ZERO;
      end
      else if (!run)
      begin
        // held at the power-up level until released to run
        in_q[i] <= clear_val;
        dac_q[i] <= clear_val;
      end
      else if (hr_act)
      begin
        // inputs are cleared too, so a later strobe cannot bring back old data
        in_q[i] <= clear_val;
        dac_q[i] <= clear_val;
      end
      else if (hit && (is_wr || is_wu))
      begin
        in_q[i] <= word_q.data;
        if (is_wu || !ld_s2_q || (ld_fall && !mask_q[i]))
        begin
          dac_q[i] <= word_q.data;
        end
      end
      else if ((hit && is_up) || (ld_fall && !mask_q[i]))
      begin
        dac_q[i] <= in_q[i];
      end
    end
  end

  assign channel_output = dac_q;
  assign gain_two = gain_q;
  assign init_done = ready_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  sequence s_mask_cmd;
    is_mask && !hr_act;
  endsequence

  sequence s_swrst_cmd;
    sw_ok;
  endsequence

  sequence s_por_end;
    (state_q != odac_pkg::ST_RUN) ##1 (state_q == odac_pkg::ST_RUN);
  endsequence

  sequence s_strobe_live;
    run && !hr_act && ld_fall && !frm_v;
  endsequence

  property p_mask_load;
    @(posedge clock) disable iff (sys_rst)
    s_mask_cmd |=> (mask_q == $past(word_q.data[7:0]));
  endproperty
  a_mask_load: assert property (p_mask_load)
    else $error("mask not loaded from data");

  property p_mask_clear;
    @(posedge clock) disable iff (sys_rst)
    s_por_end |-> (mask_q == odac_pkg::MASK_RST);
  endproperty
  a_mask_clear: assert property (p_mask_clear)
    else $error("mask not clear after reset");

  property p_masked_hold;
    @(posedge clock) disable iff (sys_rst)
    (s_strobe_live and mask_q[5]) |=> $stable(dac_q[5]);
  endproperty
  a_masked_hold: assert property (p_masked_hold)
    else $error("masked channel took strobe");

  property p_strobe_load;
    @(posedge clock) disable iff (sys_rst)
    (s_strobe_live and !mask_q[0]) |=> (dac_q[0] == $past(in_q[0]));
  endproperty
  a_strobe_load: assert property (p_strobe_load)
    else $error("strobe edge did not load channel");

  property p_write_low;
    @(posedge clock) disable iff (sys_rst)
    (is_wr && word_q.addr == 4'h5 && !hr_act && !ld_s2_q)
      |=> (dac_q[5] == $past(word_q.data)) && (in_q[5] == dac_q[5]);
  endproperty
  a_write_low: assert property (p_write_low)
    else $error("write with strobe low missed dac");

  property p_write_high;
    @(posedge clock) disable iff (sys_rst)
    (is_wr && word_q.addr == 4'h2 && !hr_act && ld_s2_q && ld_s3_q)
      |=> $stable(dac_q[2]) && (in_q[2] == $past(word_q.data));
  endproperty
  a_write_high: assert property (p_write_high)
    else $error("write with strobe high touched dac");

  property p_update;
    @(posedge clock) disable iff (sys_rst)
    (is_up && word_q.addr == 4'h3 && !hr_act)
      |=> (dac_q[3] == $past(in_q[3])) && $stable(in_q[3]);
  endproperty
  a_update: assert property (p_update)
    else $error("update command wrong");

  property p_write_upd;
    @(posedge clock) disable iff (sys_rst)
    (is_wu && word_q.addr == 4'h4 && !hr_act)
      |=> (dac_q[4] == $past(word_q.data)) && (in_q[4] == dac_q[4]);
  endproperty
  a_write_upd: assert property (p_write_upd)
    else $error("write and update wrong");

  property p_hw_clear;
    @(posedge clock) disable iff (sys_rst)
    (run && hr_act)[*2] |-> (dac_q[0] == $past(clear_val));
  endproperty
  a_hw_clear: assert property (p_hw_clear)
    else $error("output not cleared under reset pin");

  property p_power_up;
    @(posedge clock) disable iff (sys_rst)
    s_por_end |-> (dac_q[0] == $past(clear_val)) && ready_q;
  endproperty
  a_power_up: assert property (p_power_up)
    else $error("power-up level wrong");

  property p_wait_pin;
    @(posedge clock) disable iff (sys_rst)
    (state_q == odac_pkg::ST_POR && por_cnt_q == odac_pkg::POR_LAST && !hr_s2_q)
      |=> (state_q == odac_pkg::ST_WAIT) && !ready_q;
  endproperty
  a_wait_pin: assert property (p_wait_pin)
    else $error("init finished with reset pin low");

  property p_swrst;
    @(posedge clock) disable iff (sys_rst)
    s_swrst_cmd |=> (state_q == odac_pkg::ST_POR) ##1 (mask_q == odac_pkg::MASK_RST)
      && (gain_q == odac_pkg::GAIN_RST);
  endproperty
  a_swrst: assert property (p_swrst)
    else $error("software reset not taken");

  property p_swrst_bad;
    @(posedge clock) disable iff (sys_rst)
    (is_sw && !sw_ok) |=> (state_q == odac_pkg::ST_RUN);
  endproperty
  a_swrst_bad: assert property (p_swrst_bad)
    else $error("software reset ran without check word");

  property p_gain;
    @(posedge clock) disable iff (sys_rst)
    is_gain |=> (gain_two == $past(word_q.data[2]));
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain bit not taken");

  property p_frame_word;
    @(posedge link_clk) disable iff (sys_rst)
    (!frame_n && bit_cnt_q == odac_pkg::BIT_LAST)
      |=> (word_q[0] == $past(link_data)) && (tog_q != $past(tog_q));
  endproperty
  a_frame_word: assert property (p_frame_word)
    else $error("frame not completed on last bit");

endmodule

// *** tb/odac_host_model.sv ***
`timescale 1ns/1ns
// ****************************************
// host controller at the far end of the link
// ****************************************
module odac_host_model (
  output logic link_clk,
  output logic frame_n,
  output logic link_data
);
  initial
  begin
    link_clk = 1'b0;
    frame_n = 1'b1;
    link_data = 1'b1;
  end

  // clock stands still between frames; after release the data line flips so
  // a stale bit can never pass for a good one
  task automatic send_frame(input odac_pkg::odac_frame_t f);
    logic [23:0] w;
    w = f;
    frame_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      link_data = w[i];
      #6 link_clk = 1'b1;
      #6 link_clk = 1'b0;
    end
    #6 frame_n = 1'b1;
    link_data = ~w[0];
  endtask
endmodule

// *** tb/tb_odac_update_ctrl.sv ***
`timescale 1ns/1ns
module tb_odac_update_ctrl;
  logic clock;
  logic sys_rst;
  logic link_clk;
  logic frame_n;
  logic link_data;
  logic load_dac_strobe_n;
  logic hw_reset_n;
  logic reset_level_select;
  logic [7:0][15:0] channel_output;
  logic gain_two;
  logic init_done;
  logic [7:0][15:0] exp_q;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;

  odac_update_ctrl dut_u (
    .clock(clock),
    .sys_rst(sys_rst),
    .link_clk(link_clk),
    .frame_n(frame_n),
    .link_data(link_data),
    .load_dac_strobe_n(load_dac_strobe_n),
    .hw_reset_n(hw_reset_n),
    .reset_level_select(reset_level_select),
    .channel_output(channel_output),
    .gain_two(gain_two),
    .init_done(init_done)
  );

  odac_host_model host_u (
    .link_clk(link_clk),
    .frame_n(frame_n),
    .link_data(link_data)
  );

  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    compares++;
    if (seen !== want)
    begin
      bad_count++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic chk_all();
    for (int i = 0; i < 8; i++)
      chk(channel_output[i], exp_q[i]);
  endtask

  // frame crossing takes a few system clocks; 8 leaves margin
  task automatic frame(input logic [3:0] c, input logic [3:0] a, input logic [15:0] d);
    host_u.send_frame({c, a, d});
    repeat (8) @(negedge clock);
  endtask

  task automatic pulse_strobe();
    load_dac_strobe_n = 1'b0;
    repeat (4) @(negedge clock);
    load_dac_strobe_n = 1'b1;
    repeat (4) @(negedge clock);
  endtask

  task automatic wait_init();
    for (int n = 0; n < 400 && init_done !== 1'b1; n++)
      @(negedge clock);
  endtask

  task automatic end_test(input string name);
    $display("test %s finished", name);
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // sequence needs about 800 clocks
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    sys_rst = 1'b1;
    load_dac_strobe_n = 1'b1;
    hw_reset_n = 1'b1;
    reset_level_select = 1'b1;
    exp_q = {8{odac_pkg::CODE_MID}};
    repeat (16) @(negedge clock);
    sys_rst = 1'b0;
    repeat (10) @(negedge clock);
    pulse_strobe();
    chk_all();
    hw_reset_n = 1'b0;
    repeat (250) @(negedge clock);
    chk(init_done, 1'b0);
    hw_reset_n = 1'b1;
    wait_init();
    chk(init_done, 1'b1);
    chk_all();
    chk(gain_two, 1'b0);
    end_test("power_up");

    frame(odac_pkg::CMD_WRITE, 4'h2, 16'h1111);
    chk_all();
    pulse_strobe();
    exp_q[2] = 16'h1111;
    chk_all();
    frame(odac_pkg::CMD_WRITE, 4'h3, 16'h3333);
    frame(odac_pkg::CMD_UPDATE, 4'h3, 16'h5a5a);
    exp_q[3] = 16'h3333;
    chk_all();
    pulse_strobe();
    chk_all();
    frame(odac_pkg::CMD_WRITE_UPD, 4'h4, 16'h4444);
    exp_q[4] = 16'h4444;
    chk_all();
    end_test("write_update");

    // upper data byte and address must both be ignored
    frame(odac_pkg::CMD_MASK, 4'hf, 16'hff20);
    frame(odac_pkg::CMD_WRITE, 4'h5, 16'h5555);
    frame(odac_pkg::CMD_WRITE, 4'h6, 16'h6666);
    pulse_strobe();
    exp_q[6] = 16'h6666;
    chk_all();
    load_dac_strobe_n = 1'b0;
    repeat (4) @(negedge clock);
    frame(odac_pkg::CMD_WRITE, 4'h5, 16'h5050);
    exp_q[5] = 16'h5050;
    chk_all();
    load_dac_strobe_n = 1'b1;
    repeat (4) @(negedge clock);
    end_test("mask");

    frame(odac_pkg::CMD_GAIN, 4'h9, 16'h0004);
    chk(gain_two, 1'b1);
    frame(odac_pkg::CMD_GAIN, 4'h0, 16'hfff8);
    chk(gain_two, 1'b0);
    frame(odac_pkg::CMD_GAIN, 4'h0, 16'h0004);
    end_test("gain");

    // 40 clocks of 50 ns give the 2 us minimum low time
    reset_level_select = 1'b0;
    hw_reset_n = 1'b0;
    repeat (40) @(negedge clock);
    exp_q = {8{odac_pkg::CODE_ZERO}};
    chk_all();
    frame(odac_pkg::CMD_WRITE_UPD, 4'h1, 16'habcd);
    chk_all();
    hw_reset_n = 1'b1;
    repeat (6) @(negedge clock);
    chk_all();
    end_test("hw_reset");

    frame(odac_pkg::CMD_WRITE_UPD, 4'h1, 16'habcd);
    exp_q[1] = 16'habcd;
    chk_all();
    frame(4'h8, 4'h1, 16'h9999);
    frame(odac_pkg::CMD_SWRST, 4'h1, 16'h1234);
    frame(odac_pkg::CMD_SWRST, 4'h0, 16'h1235);
    chk(init_done, 1'b1);
    chk(gain_two, 1'b1);
    chk_all();
    frame(odac_pkg::CMD_SWRST, 4'h0, 16'h1234);
    chk(init_done, 1'b0);
    chk(gain_two, 1'b0);
    exp_q = {8{odac_pkg::CODE_ZERO}};
    chk_all();
    wait_init();
    chk(init_done, 1'b1);
    end_test("soft_reset");
    stop_test();
  end
endmodule
